// ---- gen_event_source_select_bench.sv ----
module gen_event_source_select_bench;
    import ges_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, rise, fall, er;
    logic [6:0] want = 7'h00, src;
    int err_total = 0, n_checks = 0, n;
    always #25 clk = ~clk;
    ges_src_model SRC (.clk_i(clk), .want_i(want), .src_o(src));
    ges_event_select DUT (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .ROUTED_INPUT_PIN_I(src[0]), .CMP1_OUT_I(src[1]), .CMP2_OUT_I(src[2]),
        .FIRST_LOGIC_CELL_OUT_I(src[3]), .FIRST_CAPTURE_COMPARE_OUT_I(src[4]),
        .SECOND_CAPTURE_COMPARE_OUT_I(src[5]), .THIRD_PULSE_MODULATOR_OUT_I(src[6]),
        .RISE_EVT_O(rise), .FALL_EVT_O(fall));
    task automatic chk(input logic [31:0] seen, exp, input string m);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %0t %s", $time, m);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // No wait count is assumed; only the watchdog ends a stuck access
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb
    // Counts edges until the event shows, so latency is measured, not assumed
    task automatic lat(input logic r);
        for (n = 1; n < 40; n++)
        begin
            @(posedge clk);
            if ((r ? rise : fall) === 1'b1)
                break;
        end
    endtask : lat
    task automatic t_regs;
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk(rd, 32'h0, "reset value");
        end
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, 8'(4 * i), 32'hFFFFFFFF);
            apb(1'b0, 8'(4 * i), 32'h0);
            chk(rd, (i < 4) ? 32'h7F : 32'h3F, "enable mask");
            apb(1'b1, 8'(4 * i), 32'h0);
        end
        pstrb <= 4'hE;
        apb(1'b1, OFS_RISE_SRC_EN, 32'h7F);
        pstrb <= 4'hF;
        apb(1'b0, OFS_RISE_SRC_EN, 32'h0);
        chk(rd, 32'h0, "strobe off");
        apb(1'b1, 8'h1C, 32'hFF);
        chk(er, 1'b1, "unmapped");
        apb(1'b0, 8'h1C, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        $display("t_regs done");
    endtask : t_regs
    task automatic t_rise_level;
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b1, OFS_RISE_SRC_EN, 32'(1 << i));
            apb(1'b1, OFS_RISE_SRC_EDGE_MODE, 32'(7'h7F ^ (7'h01 << i)));
            want <= 7'h7F ^ (7'h01 << i);
            repeat (4) @(posedge clk);
            chk(rise, 1'b0, "disabled source");
            want <= 7'h7F;
            repeat (4) @(posedge clk);
            chk(rise, 1'b1, "level rise");
            want <= 7'h00;
            repeat (4) @(posedge clk);
        end
        $display("t_rise_level done");
    endtask : t_rise_level
    task automatic t_rise_edge;
        apb(1'b1, OFS_RISE_PHASE, 32'h2);
        apb(1'b1, OFS_RISE_SRC_EDGE_MODE, 32'h01);
        apb(1'b1, OFS_RISE_SRC_EN, 32'h01);
        want <= 7'h01;
        lat(1'b1);
        chk(n, 6, "rise delay");
        repeat (3) @(posedge clk);
        chk(rise, 1'b0, "edge once");
        $display("t_rise_edge done");
    endtask : t_rise_edge
    task automatic t_fall;
        want <= 7'h7F;
        apb(1'b1, OFS_FALL_SRC_EDGE_MODE, 32'h40);
        apb(1'b1, OFS_FALL_SRC_EN, 32'h41);
        want <= 7'h77;
        repeat (4) @(posedge clk);
        chk(fall, 1'b0, "disabled low");
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'(7'h77) << STAT_LEVEL_LSB, "live levels");
        want <= 7'h76;
        repeat (4) @(posedge clk);
        chk(fall, 1'b1, "level fall");
        want <= 7'h7F;
        repeat (4) @(posedge clk);
        want <= 7'h3F;
        lat(1'b0);
        chk(n, 4, "fall delay");
        $display("t_fall done");
    endtask : t_fall
    // A second reset in mid-run must clear what software wrote
    task automatic t_reset;
        apb(1'b1, OFS_FALL_SRC_EN, 32'h7F);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, OFS_FALL_SRC_EN, 32'h0);
        chk(rd, 32'h0, "cleared again");
        $display("t_reset done");
    endtask : t_reset
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_rise_level();
        t_rise_edge();
        t_fall();
        t_reset();
        tally_and_finish();
    end
    initial
    begin
        #200000;
        err_total++;
        tally_and_finish();
    end
endmodule : gen_event_source_select_bench

// ---- ges_event_select.sv ----
module ges_event_select
    import ges_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ges_pkg::ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic ROUTED_INPUT_PIN_I,
    input wire logic CMP1_OUT_I,
    input wire logic CMP2_OUT_I,
    input wire logic FIRST_LOGIC_CELL_OUT_I,
    input wire logic FIRST_CAPTURE_COMPARE_OUT_I,
    input wire logic SECOND_CAPTURE_COMPARE_OUT_I,
    input wire logic THIRD_PULSE_MODULATOR_OUT_I,
    output logic RISE_EVT_O,
    output logic FALL_EVT_O
);
    import ges_pkg::*;

    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    logic [NUM_SRC-1:0] src;
    always_comb
    begin
        src = '0;
        src[SRC_ROUTED_PIN] = ROUTED_INPUT_PIN_I;
        src[SRC_CMP1] = CMP1_OUT_I;
        src[SRC_CMP2] = CMP2_OUT_I;
        src[SRC_LOGIC_CELL1] = FIRST_LOGIC_CELL_OUT_I;
        src[SRC_CAP_CMP1] = FIRST_CAPTURE_COMPARE_OUT_I;
        src[SRC_CAP_CMP2] = SECOND_CAPTURE_COMPARE_OUT_I;
        src[SRC_PULSE_MOD3] = THIRD_PULSE_MODULATOR_OUT_I;
    end

    ges_src_if sel_if ();

    ges_trig_detect u_detect (
        .clk_i(CLK_I),
        .rst_n_i(rst_n),
        .src_i(src),
        .sel(sel_if.det)
    );

    // Register file
    logic [NUM_SRC-1:0] rise_en_q, rise_en_d;
    logic [NUM_SRC-1:0] rise_mode_q, rise_mode_d;
    logic [NUM_SRC-1:0] fall_en_q, fall_en_d;
    logic [NUM_SRC-1:0] fall_mode_q, fall_mode_d;
    logic [PHASE_W-1:0] rise_phase_q, rise_phase_d;
    logic [PHASE_W-1:0] fall_phase_q, fall_phase_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [1:0] busy_q;
    logic wr_acc;
    logic setup;
    logic mapped;

    assign setup = PSEL_I & ~PENABLE_I;
    // Writes land only at the access edge that also sees pready high
    assign wr_acc = PSEL_I & PENABLE_I & pready_q & PWRITE_I & PSTRB_I[0];

    always_comb
    begin
        unique case (PADDR_I)
            OFS_RISE_SRC_EN, OFS_RISE_SRC_EDGE_MODE, OFS_FALL_SRC_EN,
            OFS_FALL_SRC_EDGE_MODE, OFS_RISE_PHASE, OFS_FALL_PHASE,
            OFS_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    always_comb
    begin
        rise_en_d = rise_en_q;
        rise_mode_d = rise_mode_q;
        fall_en_d = fall_en_q;
        fall_mode_d = fall_mode_q;
        rise_phase_d = rise_phase_q;
        fall_phase_d = fall_phase_q;
        if (wr_acc)
        begin
            // Bit 7 has no storage, so writes to it vanish
            unique case (PADDR_I)
                OFS_RISE_SRC_EN: rise_en_d = PWDATA_I[NUM_SRC-1:0];
                OFS_RISE_SRC_EDGE_MODE: rise_mode_d = PWDATA_I[NUM_SRC-1:0];
                OFS_FALL_SRC_EN: fall_en_d = PWDATA_I[NUM_SRC-1:0];
                OFS_FALL_SRC_EDGE_MODE: fall_mode_d = PWDATA_I[NUM_SRC-1:0];
                OFS_RISE_PHASE: rise_phase_d = PWDATA_I[PHASE_W-1:0];
                OFS_FALL_PHASE: fall_phase_d = PWDATA_I[PHASE_W-1:0];
                default: ;
            endcase
        end
    end

    always_comb
    begin
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        pready_d = setup;
        if (setup)
        begin
            prdata_d = '0;
            pslverr_d = ~mapped;
            unique case (PADDR_I)
                OFS_RISE_SRC_EN: prdata_d[NUM_SRC-1:0] = rise_en_q;
                OFS_RISE_SRC_EDGE_MODE: prdata_d[NUM_SRC-1:0] = rise_mode_q;
                OFS_FALL_SRC_EN: prdata_d[NUM_SRC-1:0] = fall_en_q;
                OFS_FALL_SRC_EDGE_MODE: prdata_d[NUM_SRC-1:0] = fall_mode_q;
                OFS_RISE_PHASE: prdata_d[PHASE_W-1:0] = rise_phase_q;
                OFS_FALL_PHASE: prdata_d[PHASE_W-1:0] = fall_phase_q;
                OFS_STATUS:
                begin
                    prdata_d[STAT_RISE_BUSY_BIT] = busy_q[DIR_RISE];
                    prdata_d[STAT_FALL_BUSY_BIT] = busy_q[DIR_FALL];
                    prdata_d[STAT_LEVEL_LSB +: NUM_SRC] = src;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rise_en_q <= SRC_RESET;
            rise_mode_q <= SRC_RESET;
            fall_en_q <= SRC_RESET;
            fall_mode_q <= SRC_RESET;
            rise_phase_q <= PHASE_RESET;
            fall_phase_q <= PHASE_RESET;
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            rise_en_q <= rise_en_d;
            rise_mode_q <= rise_mode_d;
            fall_en_q <= fall_en_d;
            fall_mode_q <= fall_mode_d;
            rise_phase_q <= rise_phase_d;
            fall_phase_q <= fall_phase_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign sel_if.rise_en = rise_en_q;
    assign sel_if.rise_mode = rise_mode_q;
    assign sel_if.fall_en = fall_en_q;
    assign sel_if.fall_mode = fall_mode_q;

    // Phase delay per direction; a new edge restarts the count
    logic [1:0][PHASE_W-1:0] cnt_q, cnt_d;
    logic [1:0] busy_d;
    logic [1:0] edge_hit;
    logic [1:0] level_hit;
    logic [1:0][PHASE_W-1:0] phase;
    logic [1:0] evt_q, evt_d;

    assign edge_hit = {sel_if.fall_edge_hit, sel_if.rise_edge_hit};
    assign level_hit = {sel_if.fall_level_hit, sel_if.rise_level_hit};
    assign phase = {fall_phase_q, rise_phase_q};

    // One process per group keeps each vector on a single driver
    always_comb
    begin
        cnt_d = cnt_q;
        busy_d = busy_q;
        evt_d = '0;
        for (int d = 0; d < 2; d++)
        begin
            if (edge_hit[d])
            begin
                cnt_d[d] = phase[d];
                busy_d[d] = 1'b1;
            end
            else if (busy_q[d])
            begin
                if (cnt_q[d] == '0)
                    busy_d[d] = 1'b0;
                else
                    cnt_d[d] = cnt_q[d] - 1'b1;
            end
            // Level triggers bypass the delay entirely
            evt_d[d] = level_hit[d] | (busy_q[d] & (cnt_q[d] == '0));
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
            busy_q <= '0;
            evt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            evt_q <= evt_d;
        end
    end

    assign PRDATA_O = prdata_q;
    assign PREADY_O = pready_q;
    assign PSLVERR_O = pslverr_q;
    assign RISE_EVT_O = evt_q[DIR_RISE];
    assign FALL_EVT_O = evt_q[DIR_FALL];
endmodule : ges_event_select

// ---- ges_event_select_assertions.sv ----
module ges_event_select_assertions
    import ges_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ges_pkg::ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic RISE_EVT_O,
    input wire logic FALL_EVT_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    property p_setup_ready; PSEL_I && !PENABLE_I |=> PREADY_O; endproperty
    a_setup_ready: assert property (p_setup_ready) else $error("no ready");
    property p_ready_pulse; PREADY_O |=> !PREADY_O; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("long ready");
    property p_ready_acc; PREADY_O |-> PSEL_I && PENABLE_I; endproperty
    a_ready_acc: assert property (p_ready_acc) else $error("stray ready");
    property p_err_rdy; PSLVERR_O |-> PREADY_O; endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("lone error");
    property p_err_zero; PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("error data");
    property p_top_zero;
        PREADY_O && !PWRITE_I && !PSLVERR_O && PADDR_I < OFS_RISE_PHASE |-> PRDATA_O[31:7] == 25'h0;
    endproperty
    a_top_zero: assert property (p_top_zero) else $error("high bits set");
    property p_rd_hold; !PSEL_I |=> $stable(PRDATA_O); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("data moved");
    property p_rst_quiet; $rose(RST_N_I) |-> (!RISE_EVT_O && !FALL_EVT_O) [*2]; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("event in reset");
    c_err: cover property (PSLVERR_O);
    c_rise: cover property (RISE_EVT_O);
    c_fall: cover property (FALL_EVT_O);
endmodule : ges_event_select_assertions
bind ges_event_select ges_event_select_assertions u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .RISE_EVT_O(RISE_EVT_O), .FALL_EVT_O(FALL_EVT_O));

// ---- ges_pkg.sv ----
// What this block does
// - Rise enable bit 7 reads zero, ignores writes
// - Rise enable bits 6..0 admit the seven sources
// - Rise mode one: rising edge, after phase delay
// - Rise mode zero: high level, immediate event
// - Rise enable zero ignores source, any mode
// - Fall enable register, same source bit order
// - Fall enable zero: source has no influence
// - Source zero is the routed input pin
// - Each mode bit pairs with same-numbered source
// - All enable and mode bits reset to zero
// - Fall mode one: falling edge, after phase delay
// - Fall mode zero: low level, immediate event
package ges_pkg;
    localparam int unsigned NUM_SRC = 7;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned PHASE_W = 6;

    localparam logic [7:0] OFS_RISE_SRC_EN = 8'h00;
    localparam logic [7:0] OFS_RISE_SRC_EDGE_MODE = 8'h04;
    localparam logic [7:0] OFS_FALL_SRC_EN = 8'h08;
    localparam logic [7:0] OFS_FALL_SRC_EDGE_MODE = 8'h0C;
    localparam logic [7:0] OFS_RISE_PHASE = 8'h10;
    localparam logic [7:0] OFS_FALL_PHASE = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    localparam int unsigned SRC_ROUTED_PIN = 0;
    localparam int unsigned SRC_CMP1 = 1;
    localparam int unsigned SRC_CMP2 = 2;
    localparam int unsigned SRC_LOGIC_CELL1 = 3;
    localparam int unsigned SRC_CAP_CMP1 = 4;
    localparam int unsigned SRC_CAP_CMP2 = 5;
    localparam int unsigned SRC_PULSE_MOD3 = 6;

    localparam int unsigned STAT_RISE_BUSY_BIT = 0;
    localparam int unsigned STAT_FALL_BUSY_BIT = 1;
    localparam int unsigned STAT_LEVEL_LSB = 8;

    localparam logic [NUM_SRC-1:0] SRC_RESET = 7'h00;
    localparam logic [PHASE_W-1:0] PHASE_RESET = 6'h00;

    typedef enum logic [0:0] {DIR_RISE, DIR_FALL} ges_dir_type;
endpackage : ges_pkg

// ---- ges_src_if.sv ----
interface ges_src_if;
    logic [6:0] rise_en;
    logic [6:0] rise_mode;
    logic [6:0] fall_en;
    logic [6:0] fall_mode;
    logic rise_edge_hit;
    logic rise_level_hit;
    logic fall_edge_hit;
    logic fall_level_hit;

    modport cfg (
        output rise_en, rise_mode, fall_en, fall_mode,
        input rise_edge_hit, rise_level_hit, fall_edge_hit, fall_level_hit
    );
    modport det (
        input rise_en, rise_mode, fall_en, fall_mode,
        output rise_edge_hit, rise_level_hit, fall_edge_hit, fall_level_hit
    );
endinterface : ges_src_if

// ---- ges_src_model.sv ----
module ges_src_model
    import ges_pkg::*;
(
    input wire logic clk_i,
    input wire logic [NUM_SRC-1:0] want_i,
    output logic [NUM_SRC-1:0] src_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Sources change just after an edge, like on-chip logic
    initial src_o = 7'h00;
    always @(posedge clk_i)
        src_o <= want_i;
endmodule : ges_src_model

// ---- ges_trig_detect.sv ----
module ges_trig_detect
    import ges_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [ges_pkg::NUM_SRC-1:0] src_i,
    ges_src_if.det sel
);
    logic [NUM_SRC-1:0] prev_q;
    logic [NUM_SRC-1:0] prev_d;
    logic [NUM_SRC-1:0] rise_edge;
    logic [NUM_SRC-1:0] fall_edge;

    function automatic logic any_hit(input logic [NUM_SRC-1:0] en,
                                     input logic [NUM_SRC-1:0] gate,
                                     input logic [NUM_SRC-1:0] hit);
        any_hit = |(en & gate & hit);
    endfunction : any_hit

    always_comb
    begin
        prev_d = src_i;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            prev_q <= '0;
        else
            prev_q <= prev_d;
    end

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++)
        begin : g_edge
            assign rise_edge[g] = src_i[g] & ~prev_q[g];
            assign fall_edge[g] = ~src_i[g] & prev_q[g];
        end
    endgenerate

    // Mode bit g gates only source g; disabled sources drop out before the OR
    assign sel.rise_edge_hit = any_hit(sel.rise_en, sel.rise_mode, rise_edge);
    assign sel.rise_level_hit = any_hit(sel.rise_en, ~sel.rise_mode, src_i);
    assign sel.fall_edge_hit = any_hit(sel.fall_en, sel.fall_mode, fall_edge);
    assign sel.fall_level_hit = any_hit(sel.fall_en, ~sel.fall_mode, ~src_i);
endmodule : ges_trig_detect
